/* File: dac_link_device.sv */
// converter front end: samples the link, updates code, mode and reference
`timescale 1ns/100ps
// Function
// - frame starts on falling sync only
// - shift data on falling clock edges
// - twenty-fourth edge executes the word
// - host may hold or raise sync after
// - host returns sync high between frames
// - host sends six leading zeros
// - bits seventeen, sixteen select power mode
// - last sixteen bits load code register
// - power-down words also load code, switch output network
// - early sync rise discards the frame
// - reset clears code and mode to zero
// - reference enabled after reset
// - reference frames need twenty-six clocks
// - disable word plus two edges turns off
// - two enable words in order re-enable
// - disabled reference releases reference pin
// - disable and enable command word values
module dac_link_device
   import dac_link_pkg::*;
(
   input wire logic clock,
   input wire logic rst_n,
   dac_link_if.device link,
   output logic [15:0] code,
   output logic [1:0] power_mode,
   output logic power_mode_high_bit,
   output logic power_mode_low_bit,
   output logic analog_enable,
   output logic analog_output_1k,
   output logic analog_output_100k,
   output logic ref_enable,
   output logic ref_pin_oe_n,
   output logic updated,
   output logic aborted
);
   logic [2:0] fs_sync, ck_sync, dt_sync;
   logic [23:0] shreg;
   logic [5:0] count;
   logic active;
   logic [23:0] held;
   logic on1_seen;
   wire fs_n = fs_sync[1];
   wire fs_fall = fs_sync[2] & ~fs_sync[1];
   wire fs_rise = ~fs_sync[2] & fs_sync[1];
   wire ck_fall = ck_sync[2] & ~ck_sync[1];
   wire sd = dt_sync[1];
   wire [23:0] next_word = {shreg[22:0], sd};
   wire take = active && !fs_n && ck_fall;
   wire at_word = take && (count == 6'(WORD_BITS - 1));
   wire at_ext = take && (count == 6'(EXT_BITS - 1));
   wire head_ok = (next_word[HEAD_HI_POS:HEAD_LO_POS] == HEAD_ZERO);
   wire [1:0] next_mode = next_word[MODE_HI_POS:MODE_LO_POS];
   wire is_off = (held == REF_OFF_WORD);
   wire is_on1 = (held == REF_ON1_WORD);
   wire is_on2 = (held == REF_ON2_WORD);
   // outputs derived from the mode bits of the incoming word
   function automatic logic [2:0] stage(input logic [1:0] m);
      stage = {m == MODE_NORMAL, m == MODE_1K, m == MODE_100K};
   endfunction
   wire [2:0] next_stage = stage(next_mode);
   // first flop of each chain feeds only the second
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         fs_sync <= 3'h7;
         ck_sync <= 3'h0;
         dt_sync <= 3'h0;
      end else begin
         fs_sync <= {fs_sync[1:0], link.frame_n};
         ck_sync <= {ck_sync[1:0], link.sclk};
         dt_sync <= {dt_sync[1:0], link.sdata};
      end
   end
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         // power-on state: zero code, normal mode
         shreg <= '0;
         count <= '0;
         active <= 1'b0;
         held <= '0;
         on1_seen <= 1'b0;
         code <= CODE_RESET;
         power_mode <= MODE_NORMAL;
         power_mode_high_bit <= 1'b0;
         power_mode_low_bit <= 1'b0;
         analog_enable <= 1'b1;
         analog_output_1k <= 1'b0;
         analog_output_100k <= 1'b0;
         ref_enable <= 1'b1;
         ref_pin_oe_n <= 1'b0;
         updated <= 1'b0;
         aborted <= 1'b0;
      end else begin
         updated <= 1'b0;
         aborted <= 1'b0;
         if (fs_fall) begin
            // new frame only on falling sync
            active <= 1'b1;
            count <= '0;
            shreg <= '0;
         end else if (fs_rise) begin
            if (active && count < 6'(WORD_BITS)) begin
               aborted <= 1'b1;
               shreg <= '0;
            end
            // any frame short of a command frame breaks the enable pair
            if (count < 6'(EXT_BITS)) on1_seen <= 1'b0;
            active <= 1'b0;
         end else if (take) begin
            // shift on falling clock while frame active
            shreg <= next_word;
            if (count != 6'h3F) count <= count + 6'd1;
            if (at_word) begin
               held <= next_word;
               // execute at 24th edge; header gate
               if (head_ok) begin
                  code <= next_word[CODE_BITS-1:0];
                  power_mode <= next_mode;
                  power_mode_high_bit <= next_mode[1];
                  power_mode_low_bit <= next_mode[0];
                  analog_enable <= next_stage[2];
                  analog_output_1k <= next_stage[1];
                  analog_output_100k <= next_stage[0];
                  updated <= 1'b1;
               end
            end
            if (at_ext) begin
               // two extra edges seal reference commands
               if (is_off) begin
                  ref_enable <= 1'b0;
                  ref_pin_oe_n <= 1'b1;
                  on1_seen <= 1'b0;
               end else if (is_on1) begin
                  on1_seen <= 1'b1;
               end else if (is_on2 && on1_seen) begin
                  ref_enable <= 1'b1;
                  ref_pin_oe_n <= 1'b0;
                  on1_seen <= 1'b0;
               end else begin
                  on1_seen <= 1'b0;
               end
            end
         end
      end
   end
endmodule

/* File: dac_link_pkg.sv */
// shared constants for the serial converter front end
package dac_link_pkg;
   localparam int WORD_BITS = 24;
   localparam int CODE_BITS = 16;
   localparam int EXT_BITS = 26;
   localparam int MODE_HI_POS = 17;
   localparam int MODE_LO_POS = 16;
   localparam int HEAD_HI_POS = 23;
   localparam int HEAD_LO_POS = 18;
   localparam logic [5:0] HEAD_ZERO = 6'h00;
   localparam logic [23:0] REF_OFF_WORD = 24'h480401;
   localparam logic [23:0] REF_ON1_WORD = 24'h4C0400;
   localparam logic [23:0] REF_ON2_WORD = 24'h4C0401;
   localparam logic [15:0] CODE_RESET = 16'h0000;
   localparam logic [1:0] MODE_NORMAL = 2'h0;
   localparam logic [1:0] MODE_1K = 2'h1;
   localparam logic [1:0] MODE_100K = 2'h2;
   localparam logic [1:0] MODE_HIZ = 2'h3;
   localparam int LINK_DIV = 16;
   localparam int IDLE_HALVES = 2;
endpackage

/* File: dac_link_if.sv */
// three-wire write link between host master and converter
`timescale 1ns/100ps
interface dac_link_if;
   logic frame_n;
   logic sclk;
   logic sdata;
   modport host (output frame_n, output sclk, output sdata);
   modport device (input frame_n, input sclk, input sdata);
endinterface

/* File: dac_link_host.sv */
// host serial master: sends 24-bit words or 26-clock extended frames
`timescale 1ns/100ps
module dac_link_host
   import dac_link_pkg::*;
#(
   parameter int DIV = LINK_DIV
) (
   input wire logic clock,
   input wire logic rst_n,
   dac_link_if.host link,
   input wire logic send,
   input wire logic [23:0] word,
   input wire logic extend,
   output logic busy,
   output logic done
);
   typedef enum logic [1:0] {
      H_IDLE = 2'b00, H_SHIFT = 2'b01, H_GAP = 2'b11
   } host_state_t;
   host_state_t state;
   logic [23:0] shreg;
   logic [5:0] edges;
   logic [5:0] total;
   logic [7:0] div_cnt;
   logic sclk_q, frame_q, data_q;
   wire half = (div_cnt == 8'(DIV / 2 - 1));
   wire last_edge = sclk_q && (edges == total - 6'd1);
   assign link.frame_n = frame_q;
   assign link.sclk = sclk_q;
   assign link.sdata = data_q;
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         state <= H_IDLE;
         shreg <= '0;
         edges <= '0;
         total <= 6'(WORD_BITS);
         div_cnt <= '0;
         sclk_q <= 1'b0;
         frame_q <= 1'b1;
         data_q <= 1'b0;
         busy <= 1'b0;
         done <= 1'b0;
      end else begin
         done <= 1'b0;
         div_cnt <= half ? 8'h00 : div_cnt + 8'h01;
         case (state)
            H_IDLE: begin
               if (send) begin
                  // frame opens with falling sync, msb first
                  frame_q <= 1'b0;
                  data_q <= word[23];
                  shreg <= {word[22:0], 1'b0};
                  // reference frames run two extra clocks
                  total <= extend ? 6'(EXT_BITS) : 6'(WORD_BITS);
                  edges <= '0;
                  sclk_q <= 1'b0;
                  div_cnt <= '0;
                  busy <= 1'b1;
                  state <= H_SHIFT;
               end
            end
            H_SHIFT: if (half) begin
               sclk_q <= ~sclk_q;
               if (sclk_q) begin
                  edges <= edges + 6'd1;
                  if (last_edge) begin
                     state <= H_GAP;
                     edges <= '0;
                  end
               end else if (edges != 6'd0) begin
                  // data moves on the rise so it is steady at the fall
                  data_q <= shreg[23];
                  shreg <= {shreg[22:0], 1'b0};
               end
            end
            H_GAP: if (half) begin
               // raise sync after last edge; hold high before next
               frame_q <= 1'b1;
               edges <= edges + 6'd1;
               if (edges == 6'(IDLE_HALVES)) begin
                  state <= H_IDLE;
                  busy <= 1'b0;
                  done <= 1'b1;
               end
            end
            default: state <= H_IDLE;
         endcase
      end
   end
endmodule

/* File: dac_link_assertions.sv */
// wire-level checks on the three-wire link
`timescale 1ns/100ps
module dac_link_assertions #(
   parameter int DIV = 16
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic frame_n,
   input wire logic sclk,
   input wire logic sdata
);
   logic sclk_q;
   int run;
   int falls;
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   // run holds the length of the level that is just ending
   always_ff @(posedge clock) begin
      sclk_q <= rst_n ? sclk : 1'b0;
      run <= (!rst_n || sclk != sclk_q) ? 1 : run + 1;
      falls <= (!rst_n || frame_n) ? 0 : falls + int'(sclk_q && !sclk);
   end
   idle_clock_low_a: assert property (frame_n |-> !sclk)
      else $error("link clock moved outside a frame");
   frame_start_a: assert property ($fell(frame_n) |-> ##[1:64] sclk)
      else $error("no clock after frame start");
   data_hold_a: assert property (sclk && sclk_q |-> $stable(sdata))
      else $error("data changed while clock high");
   half_period_a: assert property (sclk_q && !sclk |-> run == DIV / 2)
      else $error("clock high phase has wrong length");
   frame_count_a: assert property ($rose(frame_n) |-> falls inside {24, 26})
      else $error("frame ended with wrong edge count");
   fall_limit_a: assert property (falls <= 26)
      else $error("too many clock falls in a frame");
   frame_gap_a: assert property ($rose(frame_n) |=> frame_n [*8])
      else $error("frame sync gap too short");
   reset_idle_a: assert property ($rose(rst_n) |-> frame_n && !sclk)
      else $error("link not idle after reset");
endmodule

/* File: serial_dac_input_control_test.sv */
// self-checking bench: host and device joined over the link
`timescale 1ns/100ps
module serial_dac_input_control_test;
   import dac_link_pkg::*;
   localparam int DIV = 32;
   logic clock = 0, rst_n = 0, send = 0, extend = 0;
   logic [23:0] word = 24'h000000;
   logic busy, done, hi, lo, an_en, an_1k, an_100k, ref_en, oe_n, upd, abrt;
   logic [15:0] code;
   logic [1:0] mode;
   logic [15:0] exp_code = 16'h0000;
   logic [1:0] exp_mode = 2'h0;
   logic exp_ref = 1'b1;
   logic armed = 1'b0;
   int n_mismatch = 0, checks_done = 0;
   dac_link_if link();
   dac_link_host #(.DIV(DIV)) dac_link_host_i(.clock(clock), .rst_n(rst_n),
      .link(link.host), .send(send), .word(word), .extend(extend),
      .busy(busy), .done(done));
   dac_link_device dac_link_device_i(.clock(clock), .rst_n(rst_n),
      .link(link.device), .code(code), .power_mode(mode),
      .power_mode_high_bit(hi), .power_mode_low_bit(lo),
      .analog_enable(an_en), .analog_output_1k(an_1k),
      .analog_output_100k(an_100k), .ref_enable(ref_en),
      .ref_pin_oe_n(oe_n), .updated(upd), .aborted(abrt));
   dac_link_assertions #(.DIV(DIV)) dac_link_assertions_i(.clock(clock),
      .rst_n(rst_n), .frame_n(link.frame_n), .sclk(link.sclk),
      .sdata(link.sdata));
   initial forever #2.5 clock = ~clock;
   task automatic check(input logic [23:0] seen, input logic [23:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic report_and_stop();
      if (n_mismatch == 0 && checks_done > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   function automatic logic [2:0] outs_for(input logic [1:0] m);
      return {m == MODE_NORMAL, m == MODE_1K, m == MODE_100K};
   endfunction
   task automatic verify();
      check(code, exp_code);
      check({mode, hi, lo}, {exp_mode, exp_mode});
      check({an_en, an_1k, an_100k}, outs_for(exp_mode));
      check({ref_en, oe_n}, {exp_ref, !exp_ref});
   endtask
   task automatic frame(input logic [23:0] w, input logic ext);
      int i;
      logic seen_upd;
      logic seen_ab;
      i = 0;
      seen_upd = 1'b0;
      seen_ab = 1'b0;
      @(posedge clock);
      send <= 1'b1;
      word <= w;
      extend <= ext;
      @(posedge clock);
      send <= 1'b0;
      @(negedge clock);
      while (done !== 1'b1 && i < 4000) begin
         @(negedge clock);
         seen_upd = seen_upd | (upd === 1'b1);
         seen_ab = seen_ab | (abrt !== 1'b0);
         i++;
      end
      if (i == 4000) n_mismatch++;
      if (w[23:18] === HEAD_ZERO) begin
         exp_code = w[15:0];
         exp_mode = w[17:16];
      end
      // only the 26-clock command frames touch the reference
      if (ext && w === REF_OFF_WORD) exp_ref = 1'b0;
      if (ext && w === REF_ON2_WORD && armed) exp_ref = 1'b1;
      armed = ext && w === REF_ON1_WORD;
      repeat (2) @(negedge clock);
      check(seen_upd, w[23:18] === HEAD_ZERO);
      check(seen_ab, 1'b0);
      verify();
   endtask
   initial begin
      void'($urandom(32'h65bee0c4));
      repeat (8) @(posedge clock);
      rst_n <= 1'b1;
      @(negedge clock);
      verify();
      for (int k = 0; k < 12; k++) begin
         frame({6'h00, k[1:0], 16'($urandom)}, 1'b0);
      end
      frame({6'h00, 2'h0, 16'hFFFF}, 1'b1);
      frame({6'($urandom | 1), 18'($urandom)}, 1'b0);
      frame(REF_OFF_WORD, 1'b0);
      frame(REF_OFF_WORD, 1'b1);
      frame({6'h00, 2'h3, 16'h1234}, 1'b0);
      frame(REF_ON1_WORD, 1'b1);
      frame(24'h00ABCD, 1'b0);
      frame(REF_ON2_WORD, 1'b1);
      frame(REF_ON1_WORD, 1'b1);
      frame(REF_ON2_WORD, 1'b1);
      report_and_stop();
   end
   initial begin
      #400000;
      n_mismatch++;
      report_and_stop();
   end
endmodule
